// file: src/asmd_pkg.sv
// Shared constants for the servo, mute and delay control block
package asmd_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned SAMPLE_W = 24;
   localparam int unsigned RATIO_W = 16;
   localparam int unsigned PTR_W = 8;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned GAIN_W = 8;
   // ----------------------------------------------------------------
   // Counts and values after reset
   // ----------------------------------------------------------------
   localparam logic [PTR_W-1:0] OFFSET_SHORT = 8'h10;
   localparam logic [PTR_W-1:0] OFFSET_LONG = 8'h40;
   localparam logic [GAIN_W-1:0] GAIN_FULL = 8'hff;
   localparam logic [GAIN_W-1:0] GAIN_ZERO = 8'h00;
   localparam logic [RATIO_W-1:0] RATIO_RST = 16'h1000;
   localparam logic [RATIO_W-1:0] RATIO_HYST = 16'h0004;
   // Servo resolution target in picoseconds
   localparam int unsigned SETTLE_PS = 5;
   localparam logic [15:0] SETTLE_ERR_LIMIT = 16'(SETTLE_PS);
   // Fast-mode step and the error that counts as adequately settled
   localparam logic [15:0] FAST_DONE_ERR = 16'h0100;
   localparam int unsigned FAST_SHIFT = 2;
   localparam int unsigned SLOW_SHIFT = 6;
   // Gain ramp: one step every RAMP_DIV cycles
   localparam logic [7:0] RAMP_DIV = 8'h20;
   // ----------------------------------------------------------------
   // Servo states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ASMD_FAST = 2'b00,
      ASMD_SLOW = 2'b01,
      ASMD_LOCK = 2'b11
   } asmd_servo_t;
endpackage

// file: src/asmd_sync.sv
// Three-flop synchroniser with agreement-based change detection
`timescale 1ns/1ps
module asmd_sync
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic d,
   output logic q
);
   logic s1_reg, s2_reg, s3_reg, q_reg, q_next;

   // Accept a change only when the second and third stages agree
   always_comb
   begin
      q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         q_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule // asmd_sync

// file: src/asmd_fifo.sv
// Small valid/ready FIFO in the sample path
`timescale 1ns/1ps
module asmd_fifo
#(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 4
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;
   logic rdy_reg, rdy_next;

   // Pointer and fill count update
   always_comb
   begin
      push = in_valid && rdy_reg;
      pop = out_ready && (cnt_reg != '0);
      wr_next = push ? wr_reg + AW'(1) : wr_reg;
      rd_next = pop ? rd_reg + AW'(1) : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      // Ready is registered so the port comes straight from a flop
      rdy_next = (cnt_next != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         rdy_reg <= 1'b1;
      end
      else
      begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
      end
   end

   // Storage needs no reset; guarded by the count
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_reg] <= in_data;
      end
   end

   assign in_ready = rdy_reg;
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
endmodule // asmd_fifo

// file: src/asmd_top.sv
// Servo settling, soft mute, ratio hysteresis, delay offset and bypass
`timescale 1ns/1ps
// Overview of operation
// - Reset release or any rate change restarts the servo in fast mode.
// - Adequate fast settling moves to slow mode, settling until error is 5 ps.
// - Settling mute flag is high while the servo is in fast mode.
// - Mute request ramps gain down to silence; release ramps it back up.
// - Measured ratio scales the FIR convolution length when decimating.
// - Master ratio updates use hysteresis so the length scaling does not dither.
// - Phase matching: master sends its ratio, slaves use the received one.
// - Write pointer offset is 16 for short delay, 64 for long delay.
// - Bypass passes input samples straight out, no conversion or dither.
// - Delay select high picks short delay, low picks long delay.
// - Bypass mode holds while the bypass input is high.
// - Reset input is active low and holds the logic in reset.
module asmd_top
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic RATE_CHANGE,
   input wire logic [15:0] TIMING_ERR,
   input wire logic [asmd_pkg::RATIO_W-1:0] MEAS_RATIO,
   input wire logic MATCH_SLAVE,
   input wire logic [asmd_pkg::RATIO_W-1:0] PEER_RATIO,
   input wire logic MUTE_REQ,
   input wire logic DELAY_LENGTH_SELECT,
   input wire logic BYPASS_EN,
   input wire logic [asmd_pkg::PTR_W-1:0] FSIN_COUNT,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [asmd_pkg::SAMPLE_W-1:0] IN_DATA,
   input wire logic [asmd_pkg::SAMPLE_W-1:0] CONV_DATA,
   input wire logic OUT_READY,
   output logic OUT_VALID,
   output logic [asmd_pkg::SAMPLE_W-1:0] OUT_DATA,
   output logic SETTLE_MUTE,
   output logic SERVO_LOCKED,
   output logic [asmd_pkg::GAIN_W-1:0] MUTE_GAIN,
   output logic [asmd_pkg::RATIO_W-1:0] RATIO_OUT,
   output logic [asmd_pkg::RATIO_W-1:0] CONV_LENGTH,
   output logic [asmd_pkg::PTR_W-1:0] FIFO_WR_PTR,
   output logic [1:0] SERVO_SHIFT
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic rate_chg_s, mute_s, dly_s, byp_s, slave_s;

   asmd_sync u_sync_rate (.clk(CLK), .arst_n(ARST_N), .d(RATE_CHANGE),
                          .q(rate_chg_s));
   asmd_sync u_sync_mute (.clk(CLK), .arst_n(ARST_N), .d(MUTE_REQ),
                          .q(mute_s));
   asmd_sync u_sync_dly (.clk(CLK), .arst_n(ARST_N),
                         .d(DELAY_LENGTH_SELECT), .q(dly_s));
   asmd_sync u_sync_byp (.clk(CLK), .arst_n(ARST_N), .d(BYPASS_EN),
                         .q(byp_s));
   asmd_sync u_sync_slave (.clk(CLK), .arst_n(ARST_N), .d(MATCH_SLAVE),
                           .q(slave_s));

   // ----------------------------------------------------------------
   // Servo settling state machine
   // ----------------------------------------------------------------
   asmd_pkg::asmd_servo_t state_reg, state_next;
   logic rate_d_reg, rate_d_next;
   logic rate_evt;
   logic mute_flag_reg, mute_flag_next;
   logic locked_reg, locked_next;
   logic [1:0] shift_reg, shift_next;
   logic [15:0] err_abs;

   // Magnitude of the measured input-to-output timing difference
   always_comb
   begin
      err_abs = TIMING_ERR[15] ? 16'(-TIMING_ERR) : TIMING_ERR;
      rate_d_next = rate_chg_s;
      rate_evt = rate_chg_s ^ rate_d_reg;
   end

   // State moves; a rate event always wins over settling progress
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         asmd_pkg::ASMD_FAST:
         begin
            if (err_abs <= asmd_pkg::FAST_DONE_ERR)
            begin
               state_next = asmd_pkg::ASMD_SLOW;
            end
         end
         asmd_pkg::ASMD_SLOW:
         begin
            if (err_abs <= asmd_pkg::SETTLE_ERR_LIMIT)
            begin
               state_next = asmd_pkg::ASMD_LOCK;
            end
         end
         asmd_pkg::ASMD_LOCK:
         begin
            if (err_abs > asmd_pkg::SETTLE_ERR_LIMIT)
            begin
               state_next = asmd_pkg::ASMD_SLOW;
            end
         end
         default:
         begin
            state_next = asmd_pkg::ASMD_FAST;
         end
      endcase
      if (rate_evt)
      begin
         state_next = asmd_pkg::ASMD_FAST;
      end
      mute_flag_next = (state_next == asmd_pkg::ASMD_FAST);
      locked_next = (state_next == asmd_pkg::ASMD_LOCK);
      // Loop gain shift offered to the servo filter
      shift_next = (state_next == asmd_pkg::ASMD_FAST) ? 2'h0 : 2'h1;
   end

   // Reset lands in fast mode so release starts fast settling
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state_reg <= asmd_pkg::ASMD_FAST;
         rate_d_reg <= 1'b0;
         mute_flag_reg <= 1'b1;
         locked_reg <= 1'b0;
         shift_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         rate_d_reg <= rate_d_next;
         mute_flag_reg <= mute_flag_next;
         locked_reg <= locked_next;
         shift_reg <= shift_next;
      end
   end

   // ----------------------------------------------------------------
   // Soft mute gain ramp
   // ----------------------------------------------------------------
   logic [asmd_pkg::GAIN_W-1:0] gain_reg, gain_next;
   logic [7:0] div_reg, div_next;
   logic step_en;

   // Divider enable paces the ramp so it is audible as a fade
   always_comb
   begin
      step_en = (div_reg == asmd_pkg::RAMP_DIV - 8'h01);
      div_next = step_en ? 8'h00 : div_reg + 8'h01;
      gain_next = gain_reg;
      if (step_en)
      begin
         if (mute_s && gain_reg != asmd_pkg::GAIN_ZERO)
         begin
            gain_next = gain_reg - 8'h01;
         end
         else if (!mute_s && gain_reg != asmd_pkg::GAIN_FULL)
         begin
            gain_next = gain_reg + 8'h01;
         end
      end
   end

   // Starts silent: a settling device is normally muted anyway
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         gain_reg <= asmd_pkg::GAIN_ZERO;
         div_reg <= 8'h00;
      end
      else
      begin
         gain_reg <= gain_next;
         div_reg <= div_next;
      end
   end

   // ----------------------------------------------------------------
   // Ratio hysteresis, phase matching and convolution length
   // ----------------------------------------------------------------
   logic [asmd_pkg::RATIO_W-1:0] ratio_reg, ratio_next;
   logic [asmd_pkg::RATIO_W-1:0] len_reg, len_next;
   logic [asmd_pkg::RATIO_W-1:0] src_ratio, diff;

   // Master updates only when the new measure leaves the hysteresis band; slaves copy the peer
   always_comb
   begin
      src_ratio = slave_s ? PEER_RATIO : MEAS_RATIO;
      diff = (src_ratio > ratio_reg) ? src_ratio - ratio_reg
                                     : ratio_reg - src_ratio;
      ratio_next = ratio_reg;
      if (slave_s)
      begin
         ratio_next = PEER_RATIO;
      end
      else if (diff > asmd_pkg::RATIO_HYST)
      begin
         ratio_next = MEAS_RATIO;
      end
      // Ratio above unity means decimation: stretch the filter
      len_next = (ratio_reg > asmd_pkg::RATIO_RST) ? ratio_reg
                                                   : asmd_pkg::RATIO_RST;
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ratio_reg <= asmd_pkg::RATIO_RST;
         len_reg <= asmd_pkg::RATIO_RST;
      end
      else
      begin
         ratio_reg <= ratio_next;
         len_reg <= len_next;
      end
   end

   // ----------------------------------------------------------------
   // FIFO write pointer with group delay offset
   // ----------------------------------------------------------------
   logic [asmd_pkg::PTR_W-1:0] wptr_reg, wptr_next;

   always_comb
   begin
      // High select means short delay, low means long
      wptr_next = FSIN_COUNT + (dly_s ? asmd_pkg::OFFSET_SHORT
                                      : asmd_pkg::OFFSET_LONG);
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         wptr_reg <= '0;
      end
      else
      begin
         wptr_reg <= wptr_next;
      end
   end

   // ----------------------------------------------------------------
   // Output sample path through the FIFO
   // ----------------------------------------------------------------
   logic [asmd_pkg::SAMPLE_W-1:0] path_data;
   logic fifo_out_valid;
   logic [asmd_pkg::SAMPLE_W-1:0] fifo_out_data;
   logic fifo_pop;
   logic out_valid_reg, out_valid_next;
   logic [asmd_pkg::SAMPLE_W-1:0] out_data_reg, out_data_next;
   logic in_ready_reg;

   // Bypass skips the converter entirely, raw input goes out
   always_comb
   begin
      path_data = byp_s ? IN_DATA : CONV_DATA;
   end

   asmd_fifo #(.WIDTH(asmd_pkg::SAMPLE_W), .DEPTH(asmd_pkg::FIFO_DEPTH))
   u_fifo
   (
      .clk(CLK),
      .arst_n(ARST_N),
      .in_valid(IN_VALID),
      .in_ready(in_ready_reg),
      .in_data(path_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // Output stage register; refills when empty or being drained
   always_comb
   begin
      fifo_pop = fifo_out_valid && (!out_valid_reg || OUT_READY);
      out_valid_next = out_valid_reg;
      out_data_next = out_data_reg;
      if (fifo_pop)
      begin
         out_valid_next = 1'b1;
         out_data_next = fifo_out_data;
      end
      else if (OUT_READY)
      begin
         out_valid_next = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end
      else
      begin
         out_valid_reg <= out_valid_next;
         out_data_reg <= out_data_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign IN_READY = in_ready_reg;
   assign OUT_VALID = out_valid_reg;
   assign OUT_DATA = out_data_reg;
   assign SETTLE_MUTE = mute_flag_reg;
   assign SERVO_LOCKED = locked_reg;
   assign MUTE_GAIN = gain_reg;
   assign RATIO_OUT = ratio_reg;
   assign CONV_LENGTH = len_reg;
   assign FIFO_WR_PTR = wptr_reg;
   assign SERVO_SHIFT = shift_reg;
endmodule // asmd_top

// file: verif/asmd_top_assertions.sv
// Port-level checks for the servo, mute and delay control block
`timescale 1ns/1ps
module asmd_top_chk
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic RATE_CHANGE,
   input wire logic [15:0] TIMING_ERR,
   input wire logic [asmd_pkg::RATIO_W-1:0] MEAS_RATIO,
   input wire logic MATCH_SLAVE,
   input wire logic [asmd_pkg::RATIO_W-1:0] PEER_RATIO,
   input wire logic MUTE_REQ,
   input wire logic DELAY_LENGTH_SELECT,
   input wire logic [asmd_pkg::PTR_W-1:0] FSIN_COUNT,
   input wire logic SETTLE_MUTE,
   input wire logic SERVO_LOCKED,
   input wire logic [asmd_pkg::GAIN_W-1:0] MUTE_GAIN,
   input wire logic [asmd_pkg::RATIO_W-1:0] RATIO_OUT,
   input wire logic [asmd_pkg::RATIO_W-1:0] CONV_LENGTH,
   input wire logic [asmd_pkg::PTR_W-1:0] FIFO_WR_PTR,
   input wire logic [1:0] SERVO_SHIFT
);
   // Magnitude of a signed error; also used on ratio differences
   function automatic logic [15:0] mag(input logic [15:0] v);
      return v[15] ? 16'h0000 - v : v;
   endfunction
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // ----------------------------------------------------------------
   // Mode pins held long enough to clear the synchronisers
   // ----------------------------------------------------------------
   sequence short_s; DELAY_LENGTH_SELECT [*8]; endsequence
   sequence long_s; !DELAY_LENGTH_SELECT [*8]; endsequence
   sequence master_s; !MATCH_SLAVE [*8]; endsequence
   sequence slave_s; MATCH_SLAVE [*8]; endsequence
   sequence muted_s; MUTE_REQ [*8]; endsequence
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_flag_fast: assert property (SETTLE_MUTE == (SERVO_SHIFT == 2'h0))
      else $error("settle flag differs from fast mode");
   chk_fast_exit: assert property ($fell(SETTLE_MUTE) |->
      SERVO_SHIFT == 2'h1 && mag($past(TIMING_ERR)) <= asmd_pkg::FAST_DONE_ERR)
      else $error("fast mode left wrongly");
   chk_lock_err: assert property ($rose(SERVO_LOCKED) |->
      mag($past(TIMING_ERR)) <= asmd_pkg::SETTLE_ERR_LIMIT)
      else $error("lock without small error");
   chk_rate_fast: assert property ($changed(RATE_CHANGE) |->
      ##[1:8] SETTLE_MUTE) else $error("rate change did not restart");
   chk_ptr_short: assert property (short_s |=>
      FIFO_WR_PTR == $past(FSIN_COUNT) + asmd_pkg::OFFSET_SHORT)
      else $error("short offset wrong");
   chk_ptr_long: assert property (long_s |=>
      FIFO_WR_PTR == $past(FSIN_COUNT) + asmd_pkg::OFFSET_LONG)
      else $error("long offset wrong");
   chk_gain_down: assert property (muted_s |=>
      MUTE_GAIN <= $past(MUTE_GAIN)) else $error("gain rose while muted");
   chk_ratio_hyst: assert property (master_s |=> RATIO_OUT ==
      ((mag($past(MEAS_RATIO) - $past(RATIO_OUT)) > asmd_pkg::RATIO_HYST)
      ? $past(MEAS_RATIO) : $past(RATIO_OUT))) else $error("hysteresis wrong");
   chk_slave_copy: assert property (slave_s |=>
      RATIO_OUT == $past(PEER_RATIO)) else $error("peer ratio not used");
   chk_conv_len: assert property (1'b1 |=> CONV_LENGTH ==
      (($past(RATIO_OUT) > asmd_pkg::RATIO_RST) ? $past(RATIO_OUT)
      : asmd_pkg::RATIO_RST)) else $error("length scaling wrong");
endmodule // asmd_top_chk

bind asmd_top asmd_top_chk asmd_top_chk_i (.CLK(CLK), .ARST_N(ARST_N),
   .RATE_CHANGE(RATE_CHANGE), .TIMING_ERR(TIMING_ERR),
   .MEAS_RATIO(MEAS_RATIO), .MATCH_SLAVE(MATCH_SLAVE),
   .PEER_RATIO(PEER_RATIO), .MUTE_REQ(MUTE_REQ),
   .DELAY_LENGTH_SELECT(DELAY_LENGTH_SELECT), .FSIN_COUNT(FSIN_COUNT),
   .SETTLE_MUTE(SETTLE_MUTE), .SERVO_LOCKED(SERVO_LOCKED),
   .MUTE_GAIN(MUTE_GAIN), .RATIO_OUT(RATIO_OUT),
   .CONV_LENGTH(CONV_LENGTH), .FIFO_WR_PTR(FIFO_WR_PTR),
   .SERVO_SHIFT(SERVO_SHIFT));

// file: verif/asmd_sink.sv
// Output port model that takes samples with stalls
`timescale 1ns/1ps
module asmd_sink
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hold,
   input wire logic out_valid,
   input wire logic [asmd_pkg::SAMPLE_W-1:0] out_data,
   output logic out_ready,
   output logic [asmd_pkg::SAMPLE_W-1:0] got,
   output int n
);
   logic phase;
   // Ready every other cycle only, so the source must hold its word
   assign out_ready = phase && !hold;
   // Capture each accepted word and count it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase <= 1'b0;
         n <= 0;
         got <= 24'h000000;
      end
      else
      begin
         phase <= !phase;
         if (out_valid && out_ready)
         begin
            got <= out_data;
            n <= n + 1;
         end
      end
   end
endmodule // asmd_sink

// file: verif/testbench.sv
// Self-checking bench for the servo, mute and delay control block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("CHECK FAILED at %0t: value mismatch", $time); end end
module testbench;
   typedef struct {
      logic byp, sel, slv;
      logic [15:0] meas, peer;
      logic [7:0] fsin, ptr;
      logic [23:0] ind, cnv, dout;
      logic [15:0] rat, len;
   } asmd_row_t;
   logic clk, arst_n, rate, slave, mute_drv, link, sel, byp, in_valid, hold;
   logic [15:0] err, meas, peer;
   logic [7:0] fsin, ptr, gain;
   logic [23:0] in_data, conv, out_data, got;
   logic in_ready, out_ready, out_valid, settle, locked, mute_req;
   logic [15:0] ratio, clen;
   logic [1:0] shift;
   int bad_count, total_checks, nrx, n0, k, acc;
   asmd_row_t rows[4];
   // Usual wiring: the settle flag drives the mute request
   assign mute_req = link ? settle : mute_drv;
   asmd_top asmd_top_i (.CLK(clk), .ARST_N(arst_n), .RATE_CHANGE(rate),
      .TIMING_ERR(err), .MEAS_RATIO(meas), .MATCH_SLAVE(slave),
      .PEER_RATIO(peer), .MUTE_REQ(mute_req), .DELAY_LENGTH_SELECT(sel),
      .BYPASS_EN(byp), .FSIN_COUNT(fsin), .IN_VALID(in_valid),
      .IN_READY(in_ready), .IN_DATA(in_data), .CONV_DATA(conv),
      .OUT_READY(out_ready), .OUT_VALID(out_valid), .OUT_DATA(out_data),
      .SETTLE_MUTE(settle), .SERVO_LOCKED(locked), .MUTE_GAIN(gain),
      .RATIO_OUT(ratio), .CONV_LENGTH(clen), .FIFO_WR_PTR(ptr),
      .SERVO_SHIFT(shift));
   asmd_sink asmd_sink_i (.clk(clk), .arst_n(arst_n), .hold(hold),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
      .got(got), .n(nrx));
   // ----------------------------------------------------------------
   // Clock and helper tasks
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic bail(input int c, input int lim);
      if (c >= lim)
      begin
         bad_count++;
         wrap_up();
      end
   endtask
   // Holds the word until ready is seen; the caller drops valid after
   task automatic push(input logic [23:0] d, input logic [23:0] c);
      in_data = d;
      conv = c;
      in_valid = 1'b1;
      k = 0;
      while (in_ready !== 1'b1 && k < 50)
      begin
         cyc(1);
         k++;
      end
      bail(k, 50);
      cyc(1);
   endtask
   task automatic chk_reset;
      `CHK(settle, 1'b1);
      `CHK({locked, out_valid, gain}, 10'h000);
      `CHK({ratio, clen}, 32'h10001000);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rows[0] = '{0, 1, 0, 16'h1003, 0, 8'h05, 8'h15, 24'h111111,
         24'h0000aa, 24'h0000aa, 16'h1000, 16'h1000};
      rows[1] = '{1, 0, 0, 16'h1005, 0, 8'h05, 8'h45, 24'h123456,
         24'h000000, 24'h123456, 16'h1005, 16'h1005};
      rows[2] = '{0, 0, 0, 16'h0800, 0, 8'hfa, 8'h3a, 24'h222222,
         24'h00beef, 24'h00beef, 16'h0800, 16'h1000};
      rows[3] = '{1, 1, 1, 16'h0800, 16'h1234, 8'hf8, 8'h08, 24'h654321,
         24'h000000, 24'h654321, 16'h1234, 16'h1234};
      {arst_n, rate, slave, mute_drv, sel, byp, in_valid, hold} = 8'h00;
      {err, meas, peer, fsin, in_data, conv} = {16'h0200, 16'h1000, 72'h0};
      link = 1'b1;
      cyc(4);
      chk_reset();
      arst_n = 1'b1;
      // Servo: fast, slow, lock, then a rate change restarts it
      cyc(20);
      `CHK({settle, shift}, 3'h4);
      err = 16'hff80;
      cyc(3);
      `CHK({settle, shift, locked}, 4'h2);
      err = 16'h0003;
      cyc(3);
      `CHK(locked, 1'b1);
      err = 16'h0200;
      rate = 1'b1;
      cyc(10);
      `CHK({settle, shift}, 3'h4);
      err = 16'h0000;
      cyc(5);
      `CHK({settle, locked}, 2'h1);
      // Linked unmute then forced mute: each ramp takes 255 steps
      for (k = 0; k < 9000 && gain !== asmd_pkg::GAIN_FULL; k++) cyc(1);
      bail(k, 9000);
      `CHK(k >= 8000, 1'b1);
      link = 1'b0;
      mute_drv = 1'b1;
      for (k = 0; k < 9000 && gain !== asmd_pkg::GAIN_ZERO; k++) cyc(1);
      bail(k, 9000);
      `CHK(k >= 8000, 1'b1);
      mute_drv = 1'b0;
      // Table of modes: delay offset, bypass path and ratio handling
      foreach (rows[i])
      begin
         {byp, sel, slave} = {rows[i].byp, rows[i].sel, rows[i].slv};
         {meas, peer, fsin} = {rows[i].meas, rows[i].peer, rows[i].fsin};
         cyc(8);
         n0 = nrx;
         push(rows[i].ind, rows[i].cnv);
         in_valid = 1'b0;
         for (k = 0; k < 50 && nrx == n0; k++) cyc(1);
         bail(k, 50);
         `CHK(got, rows[i].dout);
         `CHK(ptr, rows[i].ptr);
         `CHK(ratio, rows[i].rat);
         cyc(2);
         `CHK(clen, rows[i].len);
      end
      // Fill the buffer against a stalled sink, then drain in order
      hold = 1'b1;
      n0 = nrx;
      for (acc = 0; acc < 8 && in_ready === 1'b1; acc++)
         push(24'(acc) + 24'h00a000, 24'h000000);
      in_valid = 1'b0;
      `CHK({in_ready, acc == 5}, 2'h1);
      hold = 1'b0;
      for (k = 0; k < 100 && nrx != n0 + acc; k++) cyc(1);
      bail(k, 100);
      `CHK(got, 24'(acc - 1) + 24'h00a000);
      // Reset in mid-run returns settle, lock, valid, gain, ratio and length to reset values
      err = 16'h0200;
      arst_n = 1'b0;
      cyc(1);
      chk_reset();
      arst_n = 1'b1;
      cyc(2);
      `CHK(settle, 1'b1);
      wrap_up();
   end
endmodule // testbench
